// file: logic/pulse_analog_consts.svh
`ifndef PULSE_ANALOG_CONSTS_SVH
`define PULSE_ANALOG_CONSTS_SVH

// Percent span in 0.01 % steps
`define PCT_FULL 14'h2710
`define GAIN_UNIT 32'h00000064
`define OFFSET_SCALE 32'h0000000A

// Pulse frequency in 0.01 kHz steps
`define PF_MIN 13'h0001
`define PF_MAX 13'h1388
`define PF_RESET 13'h1388

`define OFFSET_LIMIT 11'h3E8
`define GAIN_LIMIT 11'h3E8
`define OFFSET_RESET 11'h000
`define GAIN_RESET 11'h064

`define SEL_LAST 5'h10
`define SEL_PULSE_RESET 5'h00
`define SEL_ONE_RESET 5'h00
`define SEL_TWO_RESET 5'h01

`define SRC_RUN_FREQ 5'h00
`define SRC_SET_FREQ 5'h01
`define SRC_CURRENT 5'h02
`define SRC_TORQUE_ABS 5'h03
`define SRC_POWER 5'h04
`define SRC_VOLTAGE 5'h05
`define SRC_SPEED 5'h06
`define SRC_AMPS 5'h07
`define SRC_VOLTS 5'h08
`define SRC_TORQUE 5'h09
`define SRC_PULSE_IN 5'h0A
`define SRC_AI_ONE 5'h0B
`define SRC_AI_TWO 5'h0C
`define SRC_AI_THREE 5'h0D
`define SRC_LENGTH 5'h0E
`define SRC_COUNT 5'h0F
`define SRC_COMM 5'h10

`define AMPS_SPAN 32'h00002710
`define VOLTS_SPAN 32'h00002710
`define PULSE_IN_SPAN 32'h0000270F
`define AI_SPAN 32'h000003E8
`define COMM_SPAN 32'h00007FFF
`define BUS_NUM 32'h00000005
`define BUS_DEN 32'h00000006

`define CLK_HZ 32'h07735940
`define PULSE_UNIT_HZ 32'h0000000A

`endif

// file: logic/pulse_analog_pkg.sv
`default_nettype none
package pulse_analog_pkg;
    typedef struct packed {
        logic [2:0][4:0] sel;
        logic [12:0] pf_max;
        logic [1:0][10:0] offset;
        logic [1:0][10:0] gain;
        logic [2:0][13:0] pct;
        logic [12:0] pf_value;
        logic [1:0][14:0] ao;
        logic [24:0] acc;
        logic pulse_lvl;
    } state_t;
endpackage : pulse_analog_pkg
`default_nettype wire

// file: logic/pulse_analog_output_mapper.sv
`timescale 1ns/10ps
`default_nettype none
`include "pulse_analog_consts.svh"

module pulse_analog_output_mapper
    import pulse_analog_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic cfg_load,
    input wire logic [4:0] cfg_pulse_source_select,
    input wire logic [4:0] cfg_analog_one_source_select,
    input wire logic [4:0] cfg_analog_two_source_select,
    input wire logic [12:0] cfg_pulse_max_frequency,
    input wire logic [10:0] cfg_analog_one_offset,
    input wire logic [10:0] cfg_analog_one_gain,
    input wire logic [10:0] cfg_analog_two_offset,
    input wire logic [10:0] cfg_analog_two_gain,
    input wire logic analog_one_current_mode,
    input wire logic analog_two_current_mode,
    input wire logic [15:0] running_freq,
    input wire logic [15:0] setting_freq,
    input wire logic [15:0] max_output_freq,
    input wire logic [15:0] output_current,
    input wire logic [15:0] rated_current,
    input wire logic [15:0] torque_abs,
    input wire logic [15:0] rated_torque,
    input wire logic [15:0] output_power,
    input wire logic [15:0] rated_power,
    input wire logic [15:0] output_voltage,
    input wire logic [15:0] rated_bus_voltage,
    input wire logic [15:0] motor_speed,
    input wire logic [15:0] max_freq_speed,
    input wire logic [15:0] torque_signed,
    input wire logic [15:0] pulse_in_freq,
    input wire logic [15:0] analog_in_one,
    input wire logic [15:0] analog_in_two,
    input wire logic [15:0] analog_in_three,
    input wire logic [15:0] length_value,
    input wire logic [15:0] max_length,
    input wire logic [15:0] count_value,
    input wire logic [15:0] max_count,
    input wire logic [15:0] comm_setting,
    output logic pulse_freq_output,
    output logic [12:0] pulse_freq_value,
    output logic [14:0] analog_out_one,
    output logic [14:0] analog_out_two
);
    // Accumulator wraps at this count; adding twice the frequency word per
    // clock toggles the pin at twice the output frequency.
    localparam logic [25:0] TOGGLE_MOD = 26'(`CLK_HZ / `PULSE_UNIT_HZ);

    state_t st_reg;
    state_t st_next;

    // Quotient in 0.01 % steps, clipped at full span
    function automatic logic [13:0] ratio(input logic [31:0] num,
                                          input logic [31:0] den);
        logic [47:0] q;
        q = 48'h0;
        if (den != 32'h0) begin
            q = ({16'h0, num} * 48'(`PCT_FULL)) / {16'h0, den};
        end
        if (q > 48'(`PCT_FULL)) begin
            return `PCT_FULL;
        end
        return q[13:0];
    endfunction : ratio

    function automatic logic [13:0] pct_of(input logic [4:0] code);
        logic signed [31:0] t;
        t = $signed(32'(signed'(torque_signed))) +
            $signed(32'(rated_torque) << 1);
        case (code)
            `SRC_RUN_FREQ: return ratio(32'(running_freq),
                                       32'(max_output_freq));
            `SRC_SET_FREQ: return ratio(32'(setting_freq),
                                       32'(max_output_freq));
            `SRC_CURRENT: return ratio(32'(output_current),
                                      32'(rated_current) << 1);
            `SRC_TORQUE_ABS: return ratio(32'(torque_abs),
                                         32'(rated_torque) << 1);
            `SRC_POWER: return ratio(32'(output_power),
                                    32'(rated_power) << 1);
            `SRC_VOLTAGE: return ratio(32'(output_voltage) * `BUS_NUM,
                              32'(rated_bus_voltage) * `BUS_DEN);
            `SRC_SPEED: return ratio(32'(motor_speed),
                                    32'(max_freq_speed));
            `SRC_AMPS: return ratio(32'(output_current), `AMPS_SPAN);
            `SRC_VOLTS: return ratio(32'(output_voltage), `VOLTS_SPAN);
            `SRC_TORQUE: return (t < 0) ? 14'h0 :
                ratio(t, 32'(rated_torque) << 2);
            `SRC_PULSE_IN: return (pulse_in_freq == 16'h0) ? 14'h0 :
                ratio(32'(pulse_in_freq) - 32'h1,
                      `PULSE_IN_SPAN);
            `SRC_AI_ONE: return ratio(32'(analog_in_one),
                                     `AI_SPAN);
            `SRC_AI_TWO: return ratio(32'(analog_in_two), `AI_SPAN);
            `SRC_AI_THREE: return ratio(32'(analog_in_three), `AI_SPAN);
            `SRC_LENGTH: return ratio(32'(length_value),
                                     32'(max_length));
            `SRC_COUNT: return ratio(32'(count_value), 32'(max_count));
            `SRC_COMM: return ratio(32'(comm_setting),
                                   `COMM_SPAN);
            default: return 14'h0;
        endcase
    endfunction : pct_of

    function automatic logic [10:0] clamp_signed(input logic [10:0] v,
                                                input logic [10:0] lim);
        if ($signed(v) > $signed(lim)) begin
            return lim;
        end
        if ($signed(v) < -$signed(lim)) begin
            return -lim;
        end
        return v;
    endfunction : clamp_signed

    // Y = kX + b with k in 0.01 steps and b in 0.1 % steps
    function automatic logic [14:0] correct(input logic [13:0] x,
                                           input logic [10:0] k,
                                           input logic [10:0] b,
                                           input logic cur);
        logic signed [31:0] y;
        y = ($signed(32'(signed'(k))) * $signed(32'(x))) /
            $signed(`GAIN_UNIT) +
            $signed(32'(signed'(b))) * $signed(`OFFSET_SCALE);
        if (y < 0) begin
            y = 0;
        end
        if (y > $signed(32'(`PCT_FULL))) begin
            y = $signed(32'(`PCT_FULL));
        end
        // 0.01 % of 10 V is 1 mV; of 20 mA it is 2 uA
        return cur ? 15'(y << 1) : 15'(y);
    endfunction : correct

    always_comb begin
        logic [25:0] sum;
        logic [4:0] new_sel [3];
        logic [31:0] span;
        sum = '0;
        span = '0;
        st_next = st_reg;
        new_sel[0] = cfg_pulse_source_select;
        new_sel[1] = cfg_analog_one_source_select;
        new_sel[2] = cfg_analog_two_source_select;
        if (cfg_load) begin
            // Codes above the legal set are ignored, old choice is kept
            for (int i = 0; i < 3; i++) begin
                if (new_sel[i] <= `SEL_LAST) begin
                    st_next.sel[i] = new_sel[i];
                end
            end
            st_next.pf_max = cfg_pulse_max_frequency;
            if (cfg_pulse_max_frequency < `PF_MIN) begin
                st_next.pf_max = `PF_MIN;
            end
            if (cfg_pulse_max_frequency > `PF_MAX) begin
                st_next.pf_max = `PF_MAX;
            end
            st_next.offset[0] = clamp_signed(cfg_analog_one_offset,
                                             `OFFSET_LIMIT);
            st_next.offset[1] = clamp_signed(cfg_analog_two_offset,
                                             `OFFSET_LIMIT);
            st_next.gain[0] = clamp_signed(cfg_analog_one_gain,
                                           `GAIN_LIMIT);
            st_next.gain[1] = clamp_signed(cfg_analog_two_gain,
                                           `GAIN_LIMIT);
        end
        for (int i = 0; i < 3; i++) begin
            st_next.pct[i] = pct_of(st_reg.sel[i]);
        end
        span = 32'(st_reg.pf_max - `PF_MIN);
        st_next.pf_value = 13'(32'(`PF_MIN) +
            (32'(st_reg.pct[0]) * span) / 32'(`PCT_FULL));
        st_next.ao[0] = correct(st_reg.pct[1], st_reg.gain[0],
                                st_reg.offset[0], analog_one_current_mode);
        st_next.ao[1] = correct(st_reg.pct[2], st_reg.gain[1],
                                st_reg.offset[1], analog_two_current_mode);
        sum = {1'b0, st_reg.acc} + 26'({st_reg.pf_value, 1'b0});
        if (sum >= TOGGLE_MOD) begin
            sum = sum - TOGGLE_MOD;
            st_next.pulse_lvl = ~st_reg.pulse_lvl;
        end
        st_next.acc = sum[24:0];
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            st_reg <= '0;
            st_reg.sel[0] <= `SEL_PULSE_RESET;
            st_reg.sel[1] <= `SEL_ONE_RESET;
            st_reg.sel[2] <= `SEL_TWO_RESET;
            st_reg.pf_max <= `PF_RESET;
            st_reg.pf_value <= `PF_MIN;
            st_reg.offset <= {`OFFSET_RESET, `OFFSET_RESET};
            st_reg.gain <= {`GAIN_RESET, `GAIN_RESET};
        end else begin
            st_reg <= st_next;
        end
    end

    assign pulse_freq_output = st_reg.pulse_lvl;
    assign pulse_freq_value = st_reg.pf_value;
    assign analog_out_one = st_reg.ao[0];
    assign analog_out_two = st_reg.ao[1];

    a_select_reset: assert property (@(posedge clk_sys)
        $rose(resetn) |-> st_reg.sel[0] == 5'h00 &&
            st_reg.sel[1] == 5'h00 && st_reg.sel[2] == 5'h01)
        else $error("source selects not at reset codes");

    a_select_legal: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        st_reg.sel[0] <= 5'h10 && st_reg.sel[1] <= 5'h10 &&
            st_reg.sel[2] <= 5'h10)
        else $error("source select out of range");

    a_max_freq_range: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        st_reg.pf_max >= 13'h0001 && st_reg.pf_max <= 13'h1388)
        else $error("maximum pulse frequency out of range");

    a_pulse_span_end: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        $past(st_reg.pct[0]) == 14'h0 |-> pulse_freq_value == 13'h0001)
        else $error("pulse frequency not at floor for zero input");

    a_pulse_full_end: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        $past(st_reg.pct[0]) == 14'h2710 |->
            pulse_freq_value == $past(st_reg.pf_max))
        else $error("pulse frequency not at maximum for full input");

    a_ai_scale: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        $past(st_reg.sel[0]) == 5'h0B |-> st_reg.pct[0] ==
            (($past(analog_in_one) >= 16'h03E8) ? 14'h2710 :
             14'($past(analog_in_one) * 16'h000A)))
        else $error("analog input scaling wrong");

    a_unity_gain: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        $past(st_reg.gain[0]) == 11'h064 &&
            $past(st_reg.offset[0]) == 11'h000 &&
            !$past(analog_one_current_mode) |->
            analog_out_one == 15'($past(st_reg.pct[1])))
        else $error("unity gain output differs from standard output");

    a_analog_clamp: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        analog_out_one <= 15'h4E20 && analog_out_two <= 15'h4E20 &&
            ($past(analog_one_current_mode) || analog_out_one <= 15'h2710) &&
            ($past(analog_two_current_mode) || analog_out_two <= 15'h2710))
        else $error("analog output beyond full scale");

    a_full_offset: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        $past(st_reg.gain[1]) == 11'h000 &&
            $past(st_reg.offset[1]) == 11'h3E8 |->
            analog_out_two == ($past(analog_two_current_mode) ?
                               15'h4E20 : 15'h2710))
        else $error("full offset not at full scale");
endmodule : pulse_analog_output_mapper
`default_nettype wire

// file: verification/pulse_meter.sv
`timescale 1ns/10ps
`default_nettype none
// Measures the half period of the pulse pin in clock cycles, as a meter would
module pulse_meter (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic pulse_in,
    output var int half_cycles
);
    logic last_lvl;
    int cnt;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            last_lvl <= 1'b0;
            cnt <= 0;
            half_cycles <= 0;
        end else begin
            last_lvl <= pulse_in;
            if (pulse_in !== last_lvl) begin
                half_cycles <= cnt + 1;
                cnt <= 0;
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule : pulse_meter
`default_nettype wire

// file: verification/tb_pulse_analog_output_mapper.sv
`timescale 1ns/10ps
`default_nettype none
module tb_pulse_analog_output_mapper;
    logic clk_sys, resetn, cfg_load;
    logic analog_one_current_mode, analog_two_current_mode;
    logic [4:0] cfg_pulse_source_select, cfg_analog_one_source_select;
    logic [4:0] cfg_analog_two_source_select;
    logic [12:0] cfg_pulse_max_frequency;
    logic [10:0] cfg_analog_one_offset, cfg_analog_one_gain;
    logic [10:0] cfg_analog_two_offset, cfg_analog_two_gain;
    logic [15:0] running_freq, setting_freq, max_output_freq;
    logic [15:0] output_current, rated_current, torque_abs, rated_torque;
    logic [15:0] output_power, rated_power, output_voltage;
    logic [15:0] rated_bus_voltage, motor_speed, max_freq_speed;
    logic [15:0] torque_signed, pulse_in_freq, analog_in_one;
    logic [15:0] analog_in_two, analog_in_three, length_value, max_length;
    logic [15:0] count_value, max_count, comm_setting;
    logic pulse_freq_output;
    logic [12:0] pulse_freq_value;
    logic [14:0] analog_out_one, analog_out_two;
    int errors = 0;
    int tests_run = 0;
    int half_cycles;
    int pct;
    // Percent in 0.01 % steps per code; codes 4 and 13 saturate, 12 and 16 are exactly full
    int exp_pct [17] = '{5000, 2000, 7500, 5000, 10000, 5000, 5000, 300,
        300, 2500, 4999, 2500, 10000, 10000, 2500, 0, 10000};

    pulse_analog_output_mapper i_dut (.clk_sys, .resetn, .cfg_load,
        .cfg_pulse_source_select, .cfg_analog_one_source_select,
        .cfg_analog_two_source_select, .cfg_pulse_max_frequency,
        .cfg_analog_one_offset, .cfg_analog_one_gain, .cfg_analog_two_offset,
        .cfg_analog_two_gain, .analog_one_current_mode,
        .analog_two_current_mode, .running_freq, .setting_freq,
        .max_output_freq, .output_current, .rated_current, .torque_abs,
        .rated_torque, .output_power, .rated_power, .output_voltage,
        .rated_bus_voltage, .motor_speed, .max_freq_speed, .torque_signed,
        .pulse_in_freq, .analog_in_one, .analog_in_two, .analog_in_three,
        .length_value, .max_length, .count_value, .max_count, .comm_setting,
        .pulse_freq_output, .pulse_freq_value, .analog_out_one,
        .analog_out_two);

    pulse_meter i_meter (.clk_sys(clk_sys), .resetn(resetn),
        .pulse_in(pulse_freq_output), .half_cycles(half_cycles));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : tick

    task check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %0d expected %0d", $time,
                got, exp);
        end
    endtask : check

    task load(input logic [4:0] sp, input logic [4:0] s1,
        input logic [12:0] mx, input logic [10:0] ofs, input logic [10:0] g);
        cfg_pulse_source_select = sp;
        cfg_analog_one_source_select = s1;
        cfg_analog_two_source_select = s1;
        cfg_pulse_max_frequency = mx;
        cfg_analog_one_offset = ofs;
        cfg_analog_two_offset = ofs;
        cfg_analog_one_gain = g;
        cfg_analog_two_gain = g;
        cfg_load = 1'b1;
        tick(1);
        cfg_load = 1'b0;
        tick(4);
    endtask : load

    task do_reset;
        resetn = 1'b0;
        running_freq = 16'h09C4;
        analog_one_current_mode = 1'b0;
        analog_two_current_mode = 1'b0;
        tick(4);
        resetn = 1'b1;
        tick(4);
        check(16'(analog_out_one), 16'h1388);
        check(16'(analog_out_two), 16'h07D0);
        check(16'(pulse_freq_value), 16'h09C4);
    endtask : do_reset

    task results;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    initial begin
        #200000;
        errors++;
        results();
    end

    initial begin
        {cfg_load, analog_one_current_mode} = 2'b00;
        load_defaults_free: begin
            {cfg_pulse_source_select, cfg_analog_one_source_select} = '0;
            cfg_analog_two_source_select = '0;
            cfg_pulse_max_frequency = '0;
            {cfg_analog_one_offset, cfg_analog_one_gain} = '0;
            {cfg_analog_two_offset, cfg_analog_two_gain} = '0;
        end
        {setting_freq, max_output_freq} = {16'h03E8, 16'h1388};
        {output_current, rated_current} = {16'h012C, 16'h00C8};
        {torque_abs, rated_torque} = {16'h0064, 16'h0064};
        {output_power, rated_power} = {16'h01F4, 16'h0064};
        {output_voltage, rated_bus_voltage} = {16'h012C, 16'h01F4};
        {motor_speed, max_freq_speed} = {16'h0BB8, 16'h1770};
        {torque_signed, pulse_in_freq} = {16'hFF9C, 16'h1388};
        {analog_in_one, analog_in_two} = {16'h00FA, 16'h03E8};
        {analog_in_three, length_value} = {16'h04B0, 16'h000A};
        {max_length, count_value} = {16'h0028, 16'h0003};
        {max_count, comm_setting} = {16'h0000, 16'h7FFF};
        do_reset();
        for (int c = 0; c < 17; c++) begin
            pct = exp_pct[c];
            load(c[4:0], c[4:0], 13'h1388, 11'h000, 11'h064);
            check(16'(analog_out_one), 16'(pct));
            check(16'(pulse_freq_value), 16'(1 + pct*4999/10000));
        end
        // Codes above 16 are dropped, so code 16 at full span stays
        load(5'h11, 5'h11, 13'h1388, 11'h000, 11'h064);
        check(16'(analog_out_one), 16'h2710);
        tick(4000);
        check(16'(half_cycles), 16'h04E2);
        load(5'h10, 5'h10, 13'h1770, 11'h000, 11'h064);
        check(16'(pulse_freq_value), 16'h1388);
        load(5'h10, 5'h10, 13'h0000, 11'h000, 11'h064);
        check(16'(pulse_freq_value), 16'h0001);
        load(5'h0F, 5'h0F, 13'h1388, 11'h000, 11'h064);
        check(16'(pulse_freq_value), 16'h0001);
        analog_two_current_mode = 1'b1;
        running_freq = 16'h0000;
        load(5'h00, 5'h00, 13'h1388, 11'h320, 11'h7CE);
        check(16'(analog_out_one), 16'h1F40);
        check(16'(analog_out_two), 16'h3E80);
        running_freq = 16'h1388;
        tick(3);
        check(16'(analog_out_one), 16'h0BB8);
        check(16'(analog_out_two), 16'h1770);
        load(5'h00, 5'h00, 13'h1388, 11'h3F0, 11'h7FF);
        check(16'(analog_out_one), 16'h26AC);
        load(5'h00, 5'h00, 13'h1388, 11'h000, 11'h3E8);
        check(16'(analog_out_two), 16'h4E20);
        running_freq = 16'h00FA;
        load(5'h00, 5'h00, 13'h1388, 11'h000, 11'h3F0);
        check(16'(analog_out_one), 16'h1388);
        load(5'h00, 5'h00, 13'h1388, 11'h000, 11'h418);
        check(16'(analog_out_one), 16'h0000);
        // Zero gain with full offset, one output in each mode
        analog_one_current_mode = 1'b1;
        analog_two_current_mode = 1'b0;
        load(5'h00, 5'h00, 13'h1388, 11'h3E8, 11'h000);
        check(16'(analog_out_one), 16'h4E20);
        check(16'(analog_out_two), 16'h2710);
        do_reset();
        results();
    end
endmodule : tb_pulse_analog_output_mapper
`default_nettype wire
